/* File: gpo_pkg.sv */
// Package for the I2C four-bit output port.
// Assumes a single 100 MHz clock; bus pins are sampled in that domain.
package gpo_pkg;
	localparam logic [6:0] SLAVE_ADDR     = 7'h48;
	localparam logic [3:0] OUT_RESET      = 4'hf;
	localparam logic [3:0] UPPER_READ     = 4'hf;
	localparam int         SYNC_STAGES    = 2;
	localparam logic [3:0] BITS_PER_BYTE  = 4'h8;

	typedef struct packed {
		logic scl;
		logic sda;
	} i2c_pins_t;

	typedef enum logic [5:0] {
		ST_IDLE  = 6'b00_0001,
		ST_ADDR  = 6'b00_0010,
		ST_AACK  = 6'b00_0100,
		ST_WDATA = 6'b00_1000,
		ST_WACK  = 6'b01_0000,
		ST_RDATA = 6'b10_0000
	} bus_state_t;
endpackage

/* File: pin_sync.sv */
// Two-flop synchroniser for one asynchronous level.
// Assumes the input comes from outside the i_clk domain.
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst,
	input  wire logic i_reset_level,
	// Level
	input  wire logic i_async,
	output logic      o_sync
);
	logic meta_reg;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			meta_reg <= i_reset_level;
			o_sync   <= i_reset_level;
		end else begin
			meta_reg <= i_async;
			o_sync   <= meta_reg;
		end
	end
endmodule
`default_nettype wire

/* File: i2c_gpo.sv */
// I2C slave driving four latched push-pull output lines.
// Assumes i_rst models the power-on reset; SDA is open drain via o_sda_oe_n.
// What this block does
// - Answers only at seven-bit address 48h after a START.
// - All four lines are driven high from power-up until a write.
// - A stored one drives its line high and a zero drives it low.
// - In a write the address and then each data byte are acknowledged.
// - The upper four bits of a written byte are discarded.
// - New output value appears only after its data byte is acknowledged.
// - Any number of write bytes, each replacing the held value.
// - Read data is the level at the output pins, not the latch.
// - Any number of read bytes, pins resampled at every acknowledge.
// - In read data one means high and zero means low.
// - The upper four read bits are always ones.
// - The lines are outputs only, with no input configuration.
// - Reset puts outputs and the bus state machine in default states.
`timescale 1ns/1ps
`default_nettype none
module i2c_gpo (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	// I2C bus pins
	input  wire gpo_pkg::i2c_pins_t i_bus,
	output logic            o_sda_out,
	output logic            o_sda_oe_n,
	// Output lines and their pin levels
	input  wire logic [3:0] i_pin_level,
	output logic [3:0]      o_out_line
);
	import gpo_pkg::*;

	logic       scl_s;
	logic       sda_s;
	logic [3:0] pin_s;
	logic       scl_d_reg;
	logic       sda_d_reg;
	bus_state_t state_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] shift_reg;
	logic       rw_reg;
	logic       sda_low_reg;
	logic       got_byte_reg;
	logic [3:0] pend_reg;

	pin_sync u_scl (.i_clk(i_clk), .i_rst(i_rst), .i_reset_level(1'b1), .i_async(i_bus.scl), .o_sync(scl_s));
	pin_sync u_sda (.i_clk(i_clk), .i_rst(i_rst), .i_reset_level(1'b1), .i_async(i_bus.sda), .o_sync(sda_s));

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_pin
			pin_sync u_pin (.i_clk(i_clk), .i_rst(i_rst), .i_reset_level(1'b1),
				.i_async(i_pin_level[g]), .o_sync(pin_s[g]));
		end
	endgenerate

	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	assign scl_rise   = scl_s & ~scl_d_reg;
	assign scl_fall   = ~scl_s & scl_d_reg;
	assign start_seen = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	assign stop_seen  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

	logic       addr_match;
	logic [7:0] read_byte;
	assign addr_match = (shift_reg[7:1] == SLAVE_ADDR);
	// pins, not the latch; upper bits forced
	assign read_byte  = {UPPER_READ, pin_s};

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
		end
	end

	// Bus state machine; START always restarts, STOP always idles
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_reg    <= ST_IDLE;
			bit_cnt_reg  <= 4'h0;
			shift_reg    <= 8'h00;
			rw_reg       <= 1'b0;
			sda_low_reg  <= 1'b0;
			got_byte_reg <= 1'b0;
		end else if (start_seen) begin
			state_reg    <= ST_ADDR;
			bit_cnt_reg  <= 4'h0;
			sda_low_reg  <= 1'b0;
			got_byte_reg <= 1'b0;
		end else if (stop_seen) begin
			state_reg    <= ST_IDLE;
			sda_low_reg  <= 1'b0;
			got_byte_reg <= 1'b0;
		end else begin
			got_byte_reg <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					sda_low_reg <= 1'b0;
				end
				ST_ADDR: begin
					if (scl_rise) begin
						shift_reg   <= {shift_reg[6:0], sda_s};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end else if (scl_fall && bit_cnt_reg == BITS_PER_BYTE) begin
						bit_cnt_reg <= 4'h0;
						rw_reg      <= shift_reg[0];
						if (addr_match) begin
							state_reg   <= ST_AACK;
							sda_low_reg <= 1'b1;
						end else begin
							state_reg <= ST_IDLE;
						end
					end
				end
				ST_AACK: begin
					if (scl_fall) begin
						if (rw_reg) begin
							shift_reg   <= read_byte;
							state_reg   <= ST_RDATA;
							sda_low_reg <= ~UPPER_READ[3];
						end else begin
							state_reg   <= ST_WDATA;
							sda_low_reg <= 1'b0;
						end
					end
				end
				ST_WDATA: begin
					if (scl_rise) begin
						shift_reg   <= {shift_reg[6:0], sda_s};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end else if (scl_fall && bit_cnt_reg == BITS_PER_BYTE) begin
						bit_cnt_reg <= 4'h0;
						state_reg   <= ST_WACK;
						sda_low_reg <= 1'b1;
					end
				end
				ST_WACK: begin
					if (scl_fall) begin
						state_reg    <= ST_WDATA;
						sda_low_reg  <= 1'b0;
						got_byte_reg <= 1'b1;
					end
				end
				ST_RDATA: begin
					if (scl_fall) begin
						if (bit_cnt_reg == 4'h7) begin
							sda_low_reg <= 1'b0;
							bit_cnt_reg <= 4'h8;
						end else if (bit_cnt_reg == BITS_PER_BYTE) begin
							// Master ack: low SDA at this point was its ack
							bit_cnt_reg <= 4'h0;
							if (!sda_d_reg) begin
								shift_reg   <= read_byte;
								sda_low_reg <= ~UPPER_READ[3];
							end else begin
								state_reg <= ST_IDLE;
							end
						end else begin
							shift_reg   <= {shift_reg[6:0], 1'b1};
							sda_low_reg <= ~shift_reg[6];
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
						end
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// Data byte held until its ack clock ends
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			pend_reg <= OUT_RESET;
		end else if (state_reg == ST_WDATA && scl_fall && bit_cnt_reg == BITS_PER_BYTE) begin
			pend_reg <= shift_reg[3:0];
		end
	end

	// Output latch; lines never turn into inputs
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_out_line <= OUT_RESET;
		end else if (got_byte_reg) begin
			o_out_line <= pend_reg;
		end
	end

	// Open-drain SDA: only ever pulls low
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_sda_out  <= 1'b1;
			o_sda_oe_n <= 1'b1;
		end else begin
			o_sda_out  <= 1'b0;
			o_sda_oe_n <= ~sda_low_reg;
		end
	end
endmodule
`default_nettype wire

/* File: i2c_gpo_checker.sv */
// Port checker for i2c_gpo.
// Assumes one clock domain; bound onto every i2c_gpo.
`timescale 1ns/1ps
`default_nettype none
module i2c_gpo_checker (
	input wire logic               i_clk,
	input wire logic               i_rst,
	input wire gpo_pkg::i2c_pins_t i_bus,
	input wire logic               o_sda_out,
	input wire logic               o_sda_oe_n,
	input wire logic [3:0]         i_pin_level,
	input wire logic [3:0]         o_out_line
);
	import gpo_pkg::*;
	logic [7:0] since_reg;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// Cycles since SDA was last pulled; saturates
	always_ff @(posedge i_clk) begin
		since_reg <= i_rst ? 8'hff : !o_sda_oe_n ? 8'h00 : since_reg + {7'h00, since_reg != 8'hff};
	end
	sequence start_s;
		i_bus.scl && $fell(i_bus.sda);
	endsequence
	sequence line_move_s;
		$changed(o_out_line) && !$past(i_rst);
	endsequence
	rst_lines_a: assert property (disable iff (1'b0) i_rst |=> o_out_line == OUT_RESET)
		else $error("lines not high in reset");
	rst_sda_free_a: assert property (disable iff (1'b0) i_rst |=> o_sda_oe_n)
		else $error("sda pulled in reset");
	pull_low_a: assert property (!o_sda_oe_n |-> !o_sda_out)
		else $error("sda driven high");
	oe_scl_low_a: assert property ($changed(o_sda_oe_n) && !$past(i_rst) |-> !i_bus.scl)
		else $error("sda moved with scl high");
	out_scl_low_a: assert property (line_move_s |-> !i_bus.scl && !$past(i_bus.scl, 2))
		else $error("lines moved with scl high");
	out_after_ack_a: assert property (line_move_s |-> since_reg < 8'h3c)
		else $error("lines moved without ack");
	start_no_ack_a: assert property (start_s |-> o_sda_oe_n [*8])
		else $error("sda pulled after start");
	oe_bounded_a: assert property ($fell(o_sda_oe_n) |-> ##[1:300] o_sda_oe_n)
		else $error("sda held too long");
endmodule
bind i2c_gpo i2c_gpo_checker chk (.i_clk(i_clk), .i_rst(i_rst), .i_bus(i_bus), .o_sda_out(o_sda_out),
	.o_sda_oe_n(o_sda_oe_n), .i_pin_level(i_pin_level), .o_out_line(o_out_line));
`default_nettype wire

/* File: i2c_master_model.sv */
// I2C master model: drives SCL and open-drain SDA.
// Assumes SDA pulled up; sda_m high means released.
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
	input  wire logic clk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_m
);
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// SDA moves well clear of the SCL fall
	task automatic go(input logic d, input logic c);
		wt(6);
		sda_m = d;
		wt(16);
		scl = c;
	endtask
	task automatic start;
		go(1'b1, 1'b1);
		go(1'b0, 1'b1);
		go(1'b0, 1'b0);
	endtask
	task automatic stop;
		go(1'b0, 1'b1);
		go(1'b1, 1'b1);
	endtask
	task automatic bit_io(input logic b, output logic r);
		go(b, 1'b1);
		wt(20);
		r = sda;
		scl = 1'b0;
	endtask
	task automatic byte_tx(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(b[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask
	task automatic byte_rx(input logic more, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
		bit_io(!more, r);
	endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Testbench for i2c_gpo.
// Assumes i2c_master_model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import gpo_pkg::*;
	logic       i_clk;
	logic       i_rst;
	logic       scl;
	logic       sda_m;
	logic       o_sda_out;
	logic       o_sda_oe_n;
	logic [3:0] o_out_line;
	logic [3:0] flip;
	logic       ack;
	logic [7:0] rd;
	int         bad_count;
	int         total_checks;
	wire        sda = sda_m & (o_sda_oe_n | o_sda_out);
	i2c_master_model bus (.clk(i_clk), .sda(sda), .scl(scl), .sda_m(sda_m));
	i2c_gpo dut (.i_clk(i_clk), .i_rst(i_rst), .i_bus({scl, sda}), .o_sda_out(o_sda_out),
		.o_sda_oe_n(o_sda_oe_n), .i_pin_level(o_out_line ^ flip), .o_out_line(o_out_line));
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic t_write;
		bus.start();
		bus.byte_tx(8'h90, ack);
		chk("addr ack", 8'h01, {7'h00, ack});
		bus.byte_tx(8'h5a, ack);
		chk("data ack", 8'h01, {7'h00, ack});
		bus.wt(10);
		chk("lines", 8'h0a, {4'h0, o_out_line});
		bus.byte_tx(8'ha3, ack);
		chk("data ack 2", 8'h01, {7'h00, ack});
		bus.wt(10);
		chk("lines 2", 8'h03, {4'h0, o_out_line});
		bus.stop();
	endtask
	// Pins forced away from the latch
	task automatic t_read;
		flip = 4'h6;
		bus.start();
		bus.byte_tx(8'h91, ack);
		chk("read ack", 8'h01, {7'h00, ack});
		bus.byte_rx(1'b1, rd);
		chk("read 1", 8'hf5, rd);
		flip = 4'h9;
		bus.byte_rx(1'b1, rd);
		bus.byte_rx(1'b0, rd);
		chk("read 3", 8'hfa, rd);
		bus.stop();
		flip = 4'h0;
	endtask
	task automatic t_bad;
		bus.start();
		bus.byte_tx(8'h92, ack);
		chk("bad ack", 8'h00, {7'h00, ack});
		bus.byte_tx(8'h00, ack);
		chk("bad data ack", 8'h00, {7'h00, ack});
		bus.stop();
		chk("lines kept", 8'h03, {4'h0, o_out_line});
	endtask
	task automatic t_reset;
		i_rst = 1'b1;
		bus.wt(2);
		i_rst = 1'b0;
		chk("reset again", 8'h0f, {4'h0, o_out_line});
	endtask
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	initial begin
		repeat (20000) @(posedge i_clk);
		bad_count++;
		end_of_test();
	end
	initial begin
		i_rst = 1'b1;
		flip = 4'h0;
		bus.wt(16);
		i_rst = 1'b0;
		chk("reset lines", 8'h0f, {4'h0, o_out_line});
		bus.wt(4);
		t_write();
		t_read();
		t_bad();
		t_reset();
		end_of_test();
	end
endmodule
`default_nettype wire
